// ### src/smg_device.sv
// Serial module global control: stop, freeze, interrupts, pin control
// Contract
// - Stop bit gates module clock off
// - Stopped: only config readable, writes work
// - Stop bit written by processor, set at reset
// - Software quiesces engines before setting stop
// - Freeze with halt bit halts queue
// - Level field picks request line, zero off
// - Equal levels: queue beats async
// - Acknowledge compares mask with pending level
// - Serial arbitration using nonzero arbitration number
// - Winner drives vector, low bit by source
// - Vector resets uninitialized; software writes user vector
// - Vector low bit write ignored, reads one
// - Assignment bit picks GPIO or queue port
// - Direction bit: clear input, set output
// - Serial mode direction gates data/clock pins
// - Transmit pin direction matters only when disabled
// - Port data latched out, reads pin levels
// - Software writes port data before direction
// - Chip select 0 / slave select pin roles
// - Upper chip selects master only
// - Receive pin always async data input
// - Nine pins, eight selectable
// - Unimplemented bits ignore writes, read zero
// - Transmitter enable forces transmit pin output
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module smg_device
    import smg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    smg_link_if.device link,
    input wire logic queue_irq_req,
    input wire logic async_irq_req,
    input wire logic spi_master,
    input wire logic tx_enable,
    input wire logic miso_out,
    input wire logic mosi_out,
    input wire logic sck_out,
    input wire logic [3:0] cs_out,
    input wire logic txd_out,
    output logic clock_run,
    output logic queue_freeze_halt,
    output logic miso_in,
    output logic mosi_in,
    output logic sck_in,
    output logic slave_select_n_in,
    output logic mode_fault,
    output logic rxd_in,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [PIN_TXD:0] pin_out,
    output logic [PIN_TXD:0] pin_oe_n
);
    typedef struct packed {
        logic stop;
        logic frz_halt;
        logic frz_spare;
        logic [3:0] arb_num;
        logic [2:0] queue_lvl;
        logic [2:0] async_lvl;
        logic [7:1] vec;
        logic [7:0] assign_bits;
        logic [7:0] dir;
        logic [7:0] port;
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic rsp_valid;
        logic [7:0] rdata;
        logic [7:1] irq;
        smg_iack_e ist;
        logic [1:0] cnt;
        logic contend;
        logic src_queue;
        logic won;
        logic [7:0] vector;
    } smg_dev_s;

    smg_dev_s r, n;
    logic [2:0] q_eff;
    logic [2:0] a_eff;
    logic [2:0] pend_lvl;
    logic [7:0] cfg_rd;
    logic master;
    logic slave;

    // ==========================================================
    // Request priority
    always_comb begin
        q_eff = queue_irq_req ? r.queue_lvl : LEVEL_OFF;
        a_eff = async_irq_req ? r.async_lvl : LEVEL_OFF;
        pend_lvl = (q_eff >= a_eff) ? q_eff : a_eff;
        cfg_rd = BYTE_ZERO;
        cfg_rd[CFG_STOP] = r.stop;
        cfg_rd[CFG_FRZ_HALT] = r.frz_halt;
        cfg_rd[CFG_FRZ_SPARE] = r.frz_spare;
        cfg_rd[CFG_ARB_HI:0] = r.arb_num;
        master = spi_master;
        slave = ~spi_master;
    end

    // ==========================================================
    // Next state
    always_comb begin
        n = r;
        n.rsp_valid = 1'b0;
        n.won = r.won;
        n.sync1 = pin_in;
        n.sync2 = r.sync1;
        n.irq = '0;
        if (q_eff != LEVEL_OFF) begin
            n.irq[q_eff] = 1'b1;
        end
        if (a_eff != LEVEL_OFF) begin
            n.irq[a_eff] = 1'b1;
        end
        if (link.req_valid) begin
            n.rsp_valid = 1'b1;
            n.rdata = BYTE_ZERO;
            if (link.req_write) begin
                unique case (link.req_addr)
                    REG_CONFIG: begin
                        n.stop = link.req_wdata[CFG_STOP];
                        n.frz_halt = link.req_wdata[CFG_FRZ_HALT];
                        n.frz_spare = link.req_wdata[CFG_FRZ_SPARE];
                        n.arb_num = link.req_wdata[CFG_ARB_HI:0];
                    end
                    REG_LEVEL: begin
                        n.queue_lvl = link.req_wdata[LVL_Q_HI:LVL_Q_LO];
                        n.async_lvl = link.req_wdata[LVL_A_HI:0];
                    end
                    REG_VECTOR: n.vec = link.req_wdata[7:1];
                    REG_ASSIGN: n.assign_bits = link.req_wdata;
                    REG_DIR: n.dir = link.req_wdata;
                    REG_PORT: n.port = link.req_wdata;
                    default: n.rdata = BYTE_ZERO;
                endcase
            end else if (link.req_addr == REG_CONFIG) begin
                n.rdata = cfg_rd;
            end else if (!r.stop) begin
                unique case (link.req_addr)
                    REG_LEVEL: n.rdata = {2'b00, r.queue_lvl, r.async_lvl};
                    REG_VECTOR: n.rdata = {r.vec, 1'b1};
                    REG_ASSIGN: n.rdata = r.assign_bits;
                    REG_DIR: n.rdata = r.dir;
                    REG_PORT: n.rdata = r.sync2[PIN_TXD:0];
                    default: n.rdata = BYTE_ZERO;
                endcase
            end
        end
        unique case (r.ist)
            I_IDLE: begin
                if (link.iack_valid) begin
                    n.src_queue = (q_eff != LEVEL_OFF) && (q_eff == pend_lvl);
                    n.cnt = ARB_FIRST_BIT;
                    if ((pend_lvl > link.iack_mask) && (r.arb_num != ARB_NONE)) begin
                        n.contend = 1'b1;
                        n.ist = I_ARB;
                    end else begin
                        n.contend = 1'b0;
                        n.ist = I_DONE;
                    end
                end
            end
            I_ARB: begin
                // drop out when outbid on a bit
                if (link.arb_others && !r.arb_num[r.cnt]) begin
                    n.contend = 1'b0;
                end
                if (r.cnt == ARB_LAST_BIT) begin
                    n.ist = I_DONE;
                end else begin
                    n.cnt = r.cnt - 2'd1;
                end
            end
            I_DONE: n.ist = I_IDLE;
            default: n.ist = I_IDLE;
        endcase
        if (r.ist == I_DONE) begin
            n.won = 1'b0;
        end else if (n.ist == I_DONE) begin
            n.won = n.contend;
            n.vector = n.contend ? {r.vec, n.src_queue} : BYTE_ZERO;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '0;
            r.stop <= CONFIG_RST[CFG_STOP];
            r.vec <= VECTOR_RST[7:1];
            r.ist <= I_IDLE;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Link outputs
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_rdata = r.rdata;
    assign link.irq_lines = r.irq;
    assign link.arb_bit = (r.ist == I_ARB) && r.contend && r.arb_num[r.cnt];
    assign link.iack_done = (r.ist == I_DONE);
    assign link.iack_won = r.won;
    assign link.iack_vector = r.vector;
    assign clock_run = ~r.stop;
    // only the halt bit acts on freeze
    assign queue_freeze_halt = link.freeze & r.frz_halt;

    // ==========================================================
    // Pin control
    always_comb begin
        pin_out = r.port;
        pin_oe_n = ~r.dir;
        // assigned pins go to queue port
        if (r.assign_bits[PIN_MISO]) begin
            pin_out[PIN_MISO] = miso_out;
            pin_oe_n[PIN_MISO] = ~(slave & r.dir[PIN_MISO]);
        end
        if (r.assign_bits[PIN_MOSI]) begin
            pin_out[PIN_MOSI] = mosi_out;
            pin_oe_n[PIN_MOSI] = ~(master & r.dir[PIN_MOSI]);
        end
        if (r.assign_bits[PIN_SCK]) begin
            pin_out[PIN_SCK] = sck_out;
            pin_oe_n[PIN_SCK] = ~(master & r.dir[PIN_SCK]);
        end
        // chip select output in master mode
        if (r.assign_bits[PIN_CS0]) begin
            pin_out[PIN_CS0] = cs_out[0];
            pin_oe_n[PIN_CS0] = ~(master & r.dir[PIN_CS0]);
        end
        for (int i = PIN_CS_LO; i <= PIN_CS_HI; i++) begin
            if (r.assign_bits[i]) begin
                pin_out[i] = cs_out[i-PIN_CS0];
                pin_oe_n[i] = ~(master & r.dir[i]);
            end
        end
        pin_out[PIN_TXD] = tx_enable ? txd_out : r.port[PIN_TXD];
        pin_oe_n[PIN_TXD] = tx_enable ? 1'b0 : ~r.dir[PIN_TXD];
        miso_in = r.assign_bits[PIN_MISO] & master & ~r.dir[PIN_MISO] & r.sync2[PIN_MISO];
        mosi_in = r.assign_bits[PIN_MOSI] & slave & ~r.dir[PIN_MOSI] & r.sync2[PIN_MOSI];
        sck_in = r.assign_bits[PIN_SCK] & slave & ~r.dir[PIN_SCK] & r.sync2[PIN_SCK];
        // slave select input or mode fault
        slave_select_n_in = (r.assign_bits[PIN_CS0] & slave & ~r.dir[PIN_CS0])
            ? r.sync2[PIN_CS0] : 1'b1;
        mode_fault = r.assign_bits[PIN_CS0] & master & ~r.dir[PIN_CS0] & ~r.sync2[PIN_CS0];
        rxd_in = r.sync2[PIN_RXD];
    end
endmodule
`default_nettype wire

// ### src/smg_host.sv
// Host end: APB registers that drive the serial module link
`timescale 1ns/100ps
`default_nettype none
module smg_host
    import smg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    smg_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic freeze_in,
    input wire logic others_arb
);
    typedef struct packed {
        smg_host_e st;
        logic req_valid;
        logic req_write;
        logic [2:0] req_addr;
        logic [7:0] req_wdata;
        logic iack_valid;
        logic [2:0] iack_mask;
        logic [7:0] rdata;
        logic won;
        logic [7:0] vector;
        logic freeze;
    } smg_host_s;

    smg_host_s r, n;
    logic wr_acc;
    logic rd_acc;

    // ==========================================================
    // Orders from APB, completion from the link
    always_comb begin
        n = r;
        n.req_valid = 1'b0;
        n.iack_valid = 1'b0;
        wr_acc = psel & penable & pwrite;
        rd_acc = psel & penable & ~pwrite;
        if (wr_acc && (paddr == APB_CTRL)) begin
            n.freeze = pwdata[0];
        end
        unique case (r.st)
            H_IDLE: begin
                if (wr_acc && (paddr == APB_CMD)) begin
                    n.req_valid = 1'b1;
                    n.req_write = pwdata[CMD_WRITE];
                    n.req_addr = pwdata[2:0];
                    n.req_wdata = pwdata[CMD_WDATA_LO+7:CMD_WDATA_LO];
                    n.st = H_REG;
                end else if (wr_acc && (paddr == APB_IACK)) begin
                    n.iack_valid = 1'b1;
                    n.iack_mask = pwdata[2:0];
                    n.st = H_IACK;
                end
            end
            H_REG: begin
                if (link.rsp_valid) begin
                    n.rdata = link.rsp_rdata;
                    n.st = H_IDLE;
                end
            end
            H_IACK: begin
                if (link.iack_done) begin
                    n.won = link.iack_won;
                    n.vector = link.iack_vector;
                    n.st = H_IDLE;
                end
            end
            default: n.st = H_IDLE;
        endcase
        prdata = WORD_ZERO;
        if (rd_acc) begin
            unique case (paddr)
                APB_STATUS: begin
                    prdata[0] = (r.st != H_IDLE);
                    prdata[7:1] = link.irq_lines;
                    prdata[ST_RDATA_LO+7:ST_RDATA_LO] = r.rdata;
                    prdata[ST_WON] = r.won;
                    prdata[ST_VEC_LO+7:ST_VEC_LO] = r.vector;
                end
                APB_CTRL: prdata[0] = r.freeze;
                default: prdata = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= H_IDLE;
        end else begin
            r <= n;
        end
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign link.req_valid = r.req_valid;
    assign link.req_write = r.req_write;
    assign link.req_addr = r.req_addr;
    assign link.req_wdata = r.req_wdata;
    assign link.iack_valid = r.iack_valid;
    assign link.iack_mask = r.iack_mask;
    assign link.freeze = r.freeze | freeze_in;
    assign link.arb_others = others_arb;
endmodule
`default_nettype wire

// ### src/smg_link_if.sv
// Link between the host processor side and the serial module
`timescale 1ns/100ps
`default_nettype none
interface smg_link_if;
    logic req_valid;
    logic req_write;
    logic [2:0] req_addr;
    logic [7:0] req_wdata;
    logic rsp_valid;
    logic [7:0] rsp_rdata;
    logic freeze;
    logic iack_valid;
    logic [2:0] iack_mask;
    logic arb_others;
    logic arb_bit;
    logic iack_done;
    logic iack_won;
    logic [7:0] iack_vector;
    logic [7:1] irq_lines;

    modport device (
        input req_valid, req_write, req_addr, req_wdata, freeze,
        input iack_valid, iack_mask, arb_others,
        output rsp_valid, rsp_rdata, arb_bit, iack_done, iack_won, iack_vector, irq_lines
    );
    modport host (
        output req_valid, req_write, req_addr, req_wdata, freeze,
        output iack_valid, iack_mask, arb_others,
        input rsp_valid, rsp_rdata, arb_bit, iack_done, iack_won, iack_vector, irq_lines
    );
endinterface
`default_nettype wire

// ### src/smg_pkg.sv
// Shared constants and types for the serial module global control link
package smg_pkg;
    // ==========================================================
    // Register indices on the link
    localparam logic [2:0] REG_CONFIG = 3'h0;
    localparam logic [2:0] REG_LEVEL = 3'h1;
    localparam logic [2:0] REG_VECTOR = 3'h2;
    localparam logic [2:0] REG_ASSIGN = 3'h3;
    localparam logic [2:0] REG_DIR = 3'h4;
    localparam logic [2:0] REG_PORT = 3'h5;
    // ==========================================================
    // Config register fields
    localparam int CFG_STOP = 7;
    localparam int CFG_FRZ_HALT = 6;
    localparam int CFG_FRZ_SPARE = 5;
    localparam int CFG_ARB_HI = 3;
    // Level register fields
    localparam int LVL_Q_HI = 5;
    localparam int LVL_Q_LO = 3;
    localparam int LVL_A_HI = 2;
    // ==========================================================
    // Reset values and fixed constants
    localparam logic [7:0] CONFIG_RST = 8'h80;
    localparam logic [7:0] VECTOR_RST = 8'h0F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [3:0] ARB_NONE = 4'h0;
    localparam logic [1:0] ARB_FIRST_BIT = 2'h3;
    localparam logic [1:0] ARB_LAST_BIT = 2'h0;
    // ==========================================================
    // Pin indices
    localparam int PIN_MISO = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SCK = 2;
    localparam int PIN_CS0 = 3;
    localparam int PIN_CS_LO = 4;
    localparam int PIN_CS_HI = 6;
    localparam int PIN_TXD = 7;
    localparam int PIN_RXD = 8;
    localparam int NUM_PINS = 9;
    // ==========================================================
    // Host APB map
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_IACK = 8'h08;
    localparam logic [7:0] APB_CTRL = 8'h0C;
    localparam int CMD_WRITE = 8;
    localparam int CMD_WDATA_LO = 16;
    localparam int ST_RDATA_LO = 8;
    localparam int ST_WON = 16;
    localparam int ST_VEC_LO = 24;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        I_IDLE = 2'b00,
        I_ARB = 2'b01,
        I_DONE = 2'b10
    } smg_iack_e;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_REG = 2'b01,
        H_IACK = 2'b10
    } smg_host_e;
endpackage

// ### verif/serial_module_global_control_bench.sv
// Testbench joining the host end and the serial module
`timescale 1ns/100ps
`default_nettype none
module serial_module_global_control_bench import smg_pkg::*;;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, freeze_in, others_arb;
    logic [7:0] paddr, r, pout, poe_n;
    logic [31:0] pwdata, prdata, s;
    logic qreq, areq, master, txe, miso_o, mosi_o, sck_o, txd_o;
    logic run, qhalt, miso_i, mosi_i, sck_i, ss_n, mfault, rxd_i;
    logic [3:0] cs_o;
    logic [8:0] pin_in;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    smg_link_if lk();
    smg_host u_smg_host(.mclk(mclk), .rst_n(rst_n), .link(lk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .freeze_in(freeze_in), .others_arb(others_arb));
    smg_device u_smg_device(.mclk(mclk), .rst_n(rst_n), .link(lk), .queue_irq_req(qreq),
        .async_irq_req(areq), .spi_master(master), .tx_enable(txe), .miso_out(miso_o),
        .mosi_out(mosi_o), .sck_out(sck_o), .cs_out(cs_o), .txd_out(txd_o), .clock_run(run),
        .queue_freeze_halt(qhalt), .miso_in(miso_i), .mosi_in(mosi_i), .sck_in(sck_i),
        .slave_select_n_in(ss_n), .mode_fault(mfault), .rxd_in(rxd_i), .pin_in(pin_in),
        .pin_out(pout), .pin_oe_n(poe_n));
    smg_link_asserts u_smg_link_asserts(.mclk(mclk), .rst_n(rst_n), .req_valid(lk.req_valid),
        .req_write(lk.req_write), .req_addr(lk.req_addr), .req_wdata(lk.req_wdata),
        .rsp_valid(lk.rsp_valid), .rsp_rdata(lk.rsp_rdata), .iack_valid(lk.iack_valid),
        .iack_mask(lk.iack_mask), .iack_done(lk.iack_done), .iack_won(lk.iack_won),
        .iack_vector(lk.iack_vector), .irq_lines(lk.irq_lines));
    // ==========================================================
    // Shared tasks
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        s = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic iack(input logic [2:0] m);
        apb(1'h1, APB_IACK, {29'h0, m});
        do apb(1'h0, APB_STATUS, WORD_ZERO); while (s[0] !== 1'h0);
    endtask
    task automatic dev(input logic w, input logic [2:0] i, input logic [7:0] d);
        apb(1'h1, APB_CMD, {8'h00, d, 7'h00, w, 5'h00, i});
        do apb(1'h0, APB_STATUS, WORD_ZERO); while (s[0] !== 1'h0);
        r = s[15:8];
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_stop();
        dev(1'h0, REG_CONFIG, 8'h00);
        ck("config", CONFIG_RST, r);
        ck("run", 1'h0, run);
        dev(1'h1, REG_LEVEL, 8'h1B);
        dev(1'h0, REG_LEVEL, 8'h00);
        ck("stopped", 8'h00, r);
        dev(1'h1, REG_CONFIG, 8'h01);
        ck("running", 1'h1, run);
        dev(1'h0, REG_LEVEL, 8'h00);
        ck("level", 8'h1B, r);
        dev(1'h0, REG_VECTOR, 8'h00);
        ck("vecrst", VECTOR_RST, r);
        dev(1'h1, REG_VECTOR, 8'h40);
        dev(1'h0, REG_VECTOR, 8'h00);
        ck("vector", 8'h41, r);
    endtask
    task automatic t_irq();
        qreq <= 1'h1;
        areq <= 1'h1;
        apb(1'h0, APB_STATUS, WORD_ZERO);
        ck("lines", 7'h04, s[7:1]);
        iack(3'h2);
        ck("won", 1'h1, s[16]);
        ck("qvec", 8'h41, s[31:24]);
        qreq <= 1'h0;
        iack(3'h2);
        ck("avec", 8'h40, s[31:24]);
        iack(3'h7);
        ck("masked", 1'h0, s[16]);
        others_arb <= 1'h1;
        iack(3'h2);
        ck("lost", 1'h0, s[16]);
        others_arb <= 1'h0;
        dev(1'h1, REG_LEVEL, 8'h38);
        qreq <= 1'h1;
        apb(1'h0, APB_STATUS, WORD_ZERO);
        ck("top", 7'h40, s[7:1]);
    endtask
    task automatic t_freeze();
        freeze_in <= 1'h1;
        dev(1'h1, REG_CONFIG, 8'h21);
        ck("spare", 1'h0, qhalt);
        dev(1'h1, REG_CONFIG, 8'h41);
        ck("halt", 1'h1, qhalt);
        freeze_in <= 1'h0;
        apb(1'h1, APB_CTRL, 32'h0000_0001);
        // Control bit lands at the access edge
        @(posedge mclk);
        ck("ctrl", 1'h1, qhalt);
        apb(1'h1, APB_CTRL, WORD_ZERO);
        apb(1'h0, APB_CTRL, WORD_ZERO);
        ck("ctrlrd", WORD_ZERO, s);
        ck("off", 1'h0, qhalt);
    endtask
    task automatic t_pins();
        dev(1'h1, REG_PORT, 8'hA5);
        dev(1'h1, REG_DIR, 8'hFF);
        ck("out", 8'hA5, pout);
        ck("oe", 8'h00, poe_n);
        dev(1'h1, REG_DIR, 8'h00);
        txe <= 1'h1;
        @(posedge mclk);
        ck("txoe", 8'h7F, poe_n);
        ck("txd", 1'h0, pout[7]);
        txe <= 1'h0;
        pin_in <= 9'h13D;
        repeat (3) @(posedge mclk);
        dev(1'h0, REG_PORT, 8'h00);
        ck("pins", 8'h3D, r);
        ck("rxd", 1'h1, rxd_i);
        dev(1'h1, REG_ASSIGN, 8'h7F);
        dev(1'h1, REG_DIR, 8'h06);
        ck("moe", 8'hF9, poe_n);
        ck("mosi", 1'h1, pout[1]);
        ck("miso", 1'h1, miso_i);
        pin_in <= 9'h135;
        repeat (3) @(posedge mclk);
        ck("fault", 1'h1, mfault);
        master <= 1'h0;
        dev(1'h1, REG_DIR, 8'h71);
        ck("soe", 8'hFE, poe_n);
        ck("ss", 1'h0, ss_n);
        ck("sck", 1'h1, sck_i);
        ck("slvmosi", 1'h0, mosi_i);
        ck("nofault", 1'h0, mfault);
        dev(1'h1, REG_CONFIG, 8'hC1);
        ck("stop", 1'h0, run);
        dev(1'h0, REG_CONFIG, 8'h00);
        ck("cfgstop", 8'hC1, r);
        dev(1'h0, REG_PORT, 8'h00);
        ck("portstop", 8'h00, r);
    endtask
    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, freeze_in, others_arb, qreq, areq} = 8'h00;
        {txe, miso_o, sck_o, txd_o} = 4'h0;
        {master, mosi_o} = 2'h3;
        paddr = 8'h00;
        pwdata = WORD_ZERO;
        cs_o = 4'h0;
        pin_in = 9'h000;
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        t_stop();
        t_irq();
        t_freeze();
        t_pins();
        complete_run();
    end
endmodule
`default_nettype wire

// ### verif/smg_link_asserts.sv
// Link checker for the serial module global control pair
`timescale 1ns/100ps
`default_nettype none
module smg_link_asserts
    import smg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_rdata,
    input wire logic iack_valid,
    input wire logic [2:0] iack_mask,
    input wire logic iack_done,
    input wire logic iack_won,
    input wire logic [7:0] iack_vector,
    input wire logic [7:1] irq_lines
);
    // ==========================================================
    // Shadow of the device registers
    logic [6:0] vec_r;
    logic [5:0] lvl_r;
    logic stop_r;
    logic rd;
    assign rd = req_valid && !req_write;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            vec_r <= VECTOR_RST[7:1];
            lvl_r <= 6'h00;
            stop_r <= 1'h1;
        end else if (req_valid && req_write) begin
            if (req_addr == REG_VECTOR) vec_r <= req_wdata[7:1];
            if (req_addr == REG_LEVEL) lvl_r <= req_wdata[5:0];
            if (req_addr == REG_CONFIG) stop_r <= req_wdata[CFG_STOP];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Properties
    resp_timing_a: assert property (req_valid |=> rsp_valid)
        else $error("response missing one cycle after request");
    resp_alone_a: assert property (!req_valid |=> !rsp_valid)
        else $error("response without request");
    stop_read_a: assert property (
        rd && req_addr != REG_CONFIG && stop_r |=> rsp_rdata == BYTE_ZERO)
        else $error("read while stopped not zero");
    vector_read_a: assert property (
        rd && req_addr == REG_VECTOR && !stop_r |=> rsp_rdata == {vec_r, 1'h1})
        else $error("vector read wrong");
    config_gap_a: assert property (rd && req_addr == REG_CONFIG |=> !rsp_rdata[4])
        else $error("config unused bit not zero");
    level_gap_a: assert property (
        rd && req_addr == REG_LEVEL && !stop_r |=> rsp_rdata == {2'h0, lvl_r})
        else $error("level read wrong");
    iack_bound_a: assert property (iack_valid |-> ##[1:5] iack_done)
        else $error("acknowledge not finished in five cycles");
    mask_high_a: assert property (
        iack_valid && iack_mask == 3'h7 |=> iack_done && !iack_won)
        else $error("contended above mask");
    win_vector_a: assert property (
        iack_done && iack_won |-> iack_vector[7:1] == vec_r)
        else $error("winning vector upper bits wrong");
    level_off_a: assert property (
        lvl_r == 6'h00 && $stable(lvl_r) |-> irq_lines == 7'h00)
        else $error("request line with levels off");
endmodule
`default_nettype wire
